// [core/oag_pkg.sv]
package oag_pkg;
    // ------------------------------------------------------------
    // Field encodings
    // ------------------------------------------------------------
    localparam logic [1:0] AM_REG      = 2'h0;
    localparam logic [1:0] AM_REG_INC  = 2'h1;
    localparam logic [1:0] AM_DISP     = 2'h2;
    localparam logic [1:0] AM_INDIRECT = 2'h3;

    // Indirect sub-forms under addressing field 11
    localparam logic [1:0] IND_BYTE_DISP = 2'h0;
    localparam logic [1:0] IND_TWO_DISP  = 2'h1;
    localparam logic [1:0] IND_LONG      = 2'h2;

    // Operand sizes
    localparam logic [1:0] SIZE_BYTE   = 2'h0;
    localparam logic [1:0] SIZE_WORD   = 2'h1;
    localparam logic [1:0] SIZE_DOUBLE = 2'h2;

    // ------------------------------------------------------------
    // Limits
    // ------------------------------------------------------------
    localparam logic [15:0] JUMP_DISP_MIN = 16'hff00;
    localparam logic [15:0] JUMP_DISP_MAX = 16'h00fe;
    localparam logic [4:0]  SINGLE_SHIFT_MAX = 5'h10;
    localparam logic [4:0]  PAIR_SHIFT_MAX   = 5'h1f;
    localparam logic [5:0]  SHORT_DISP_MAX   = 6'h3e;
    localparam logic [15:0] WORK_AREA_MAX    = 16'h3ffe;
    localparam int          FLOAT_REGS       = 4;
    localparam int          GEN_REGS         = 8;

    // Opcode group and invalid function codes (C..F)
    localparam logic [3:0] RS_GROUP_OP     = 4'hc;
    localparam logic [3:0] FUNC_INVALID_LO = 4'hc;

    typedef enum logic [1:0] {
        SIZE_B, SIZE_W, SIZE_D
    } unused_size_type;
endpackage

// [core/limit_checker.sv]
module limit_checker
    import oag_pkg::*;
(
    // Values under test
    input  wire logic [15:0] jumpDisp,
    input  wire logic [4:0]  singleShiftCount,
    input  wire logic [4:0]  pairShiftCount,
    input  wire logic [15:0] workAreaSize,
    // Verdicts
    output logic             jumpOk,
    output logic             singleShiftOk,
    output logic             pairShiftOk,
    output logic             workAreaOk
);
    // Signed compare on the raw 16-bit field
    assign jumpOk = ($signed(jumpDisp) >= $signed(JUMP_DISP_MIN))
                 && ($signed(jumpDisp) <= $signed(JUMP_DISP_MAX))
                 && !jumpDisp[0];                          // [RULE_09]
    assign singleShiftOk = singleShiftCount <= SINGLE_SHIFT_MAX; // [RULE_10]
    assign pairShiftOk   = pairShiftCount <= PAIR_SHIFT_MAX;     // [RULE_10]
    assign workAreaOk    = (workAreaSize <= WORK_AREA_MAX)
                        && !workAreaSize[0];                     // [RULE_13]
endmodule

// [core/float_reg_file.sv]
module float_reg_file
    import oag_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // Write port
    input  wire logic        wrEn,
    input  wire logic [1:0]  wrSel,
    input  wire logic [31:0] wrData,
    // Read port
    input  wire logic [1:0]  rdSel,
    output logic      [31:0] rdData
);
    typedef struct packed {
        logic [FLOAT_REGS-1:0][31:0] regs;
        logic [31:0]                 rd;
    } fstate_type;

    fstate_type stateReg;
    fstate_type stateNext;

    always_comb begin
        stateNext = stateReg;
        if (wrEn) begin
            stateNext.regs[wrSel] = wrData;                      // [RULE_14]
        end
        stateNext.rd = stateNext.regs[rdSel];                    // [RULE_14]
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            stateReg <= '0;
        end else begin
            stateReg <= stateNext;
        end
    end

    assign rdData = stateReg.rd;
endmodule

// [core/operand_address_generator.sv]
// Notes on behaviour
// [RULE_01] Field 00: effective address is the register contents unchanged.
// [RULE_02] Field 01: use register, then add operand size 1, 2 or 4.
// [RULE_03] Field 10: base plus 16-bit displacement, modulo 65536.
// [RULE_04] Two-displacement form: fetch at base+inner, add outer displacement.
// [RULE_05] Single indirect: fetch at base plus 8-bit unsigned displacement.
// [RULE_06] Two-bit format bases 1-3; three-bit format bases 1-7.
// [RULE_07] Byte operand addresses may be odd or even.
// [RULE_08] Program supplies even addresses for word and doubleword operands.
// [RULE_09] Jump target is next byte plus even displacement -256..+254.
// [RULE_10] Single shift counts 0..16, pair shift counts 0..31.
// [RULE_11] Short format adds even 0..62 displacement, optional indirect fetch.
// [RULE_12] Long indirect: base 1-7 plus word displacement, fetch result.
// [RULE_13] Work-area size is an even byte count up to 16382.
// [RULE_14] Four floating-point registers numbered 0 through 3.
// [RULE_15] Invalid function codes in storage group raise program check.
module operand_address_generator
    import oag_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // Decode request
    input  wire logic        reqValid,
    output logic             reqReady,
    input  wire logic [1:0]  operandAddressingField,
    input  wire logic [1:0]  indirectForm,
    input  wire logic        shortForm,
    input  wire logic        shortIndirect,
    input  wire logic        threeBitRegOperand,
    input  wire logic [2:0]  regSel,
    input  wire logic [1:0]  operandSize,
    input  wire logic [15:0] outerDisplacement,
    input  wire logic [15:0] innerDisplacement,
    input  wire logic [3:0]  opGroup,
    input  wire logic [3:0]  funcCode,
    // Jump
    input  wire logic        jumpValid,
    input  wire logic [15:0] nextInstrAddr,
    input  wire logic [15:0] jumpDisp,
    // Range checks
    input  wire logic [4:0]  singleShiftCount,
    input  wire logic [4:0]  pairShiftCount,
    input  wire logic [15:0] workAreaSize,
    output logic             singleShiftOk,
    output logic             pairShiftOk,
    output logic             workAreaOk,
    // General register write (load)
    input  wire logic        gprWrEn,
    input  wire logic [2:0]  gprWrSel,
    input  wire logic [15:0] gprWrData,
    // Floating register file
    input  wire logic        fprWrEn,
    input  wire logic [1:0]  fprWrSel,
    input  wire logic [31:0] fprWrData,
    input  wire logic [1:0]  fprRdSel,
    output logic      [31:0] fprRdData,
    // Storage read port
    output logic             memReq,
    output logic      [15:0] memAddr,
    input  wire logic        memAck,
    input  wire logic [15:0] memData,
    // Results
    output logic             doneValid,
    output logic      [15:0] effAddr,
    output logic             jumpDone,
    output logic      [15:0] jumpTarget,
    output logic             jumpError,
    output logic             baseError,
    output logic             alignError,
    output logic             programCheck
);
    typedef enum logic [1:0] {
        ST_IDLE, ST_FETCH, ST_DONE
    } phase_type;

    typedef struct packed {
        phase_type         phase;
        logic [7:0][15:0]  gpr;
        logic [15:0]       memAddr;
        logic [15:0]       addAfter;
        logic              addOuter;
        logic              done;
        logic [15:0]       ea;
        logic              jDone;
        logic [15:0]       jTarget;
        logic              jErr;
        logic              baseErr;
        logic              alignErr;
        logic              pCheck;
    } state_type;

    state_type stateReg;
    state_type stateNext;

    logic jumpOk;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] size_bytes(input logic [1:0] sz);
        case (sz)
            SIZE_BYTE: size_bytes = 16'h0001;
            SIZE_WORD: size_bytes = 16'h0002;
            default:   size_bytes = 16'h0004;
        endcase
    endfunction

    function automatic logic base_legal(input logic threeBit,
                                        input logic [2:0] r);
        if (threeBit) begin
            base_legal = r != 3'h0;
        end else begin
            base_legal = (r != 3'h0) && !r[2];
        end
    endfunction

    // ------------------------------------------------------------
    // Sub-blocks
    // ------------------------------------------------------------
    limit_checker u_limit_checker (
        .jumpDisp         (jumpDisp),
        .singleShiftCount (singleShiftCount),
        .pairShiftCount   (pairShiftCount),
        .workAreaSize     (workAreaSize),
        .jumpOk           (jumpOk),
        .singleShiftOk    (singleShiftOk),
        .pairShiftOk      (pairShiftOk),
        .workAreaOk       (workAreaOk)
    );

    float_reg_file u_float_reg_file (
        .clk    (clk),
        .srst   (srst),
        .wrEn   (fprWrEn),
        .wrSel  (fprWrSel),
        .wrData (fprWrData),
        .rdSel  (fprRdSel),
        .rdData (fprRdData)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [15:0] base;
        logic [2:0]  r;
        logic        isDispMode;
        logic [15:0] ea;
        base = '0;
        r = '0;
        isDispMode = 1'b0;
        ea = '0;
        stateNext = stateReg;
        stateNext.done = 1'b0;
        stateNext.jDone = 1'b0;
        if (gprWrEn) begin
            stateNext.gpr[gprWrSel] = gprWrData;
        end
        // Jump path works alongside operand decode
        if (jumpValid) begin
            stateNext.jDone = 1'b1;
            stateNext.jErr = !jumpOk;                          // [RULE_09]
            stateNext.jTarget = nextInstrAddr + jumpDisp;     // [RULE_09]
        end
        case (stateReg.phase)
            ST_IDLE: begin
                if (reqValid) begin
                    // Two-bit format holds only registers 0..3
                    r = threeBitRegOperand ? regSel : {1'b0, regSel[1:0]};
                    base = stateReg.gpr[r];
                    isDispMode = !shortForm && operandAddressingField[1];
                    stateNext.baseErr = isDispMode
                        && !base_legal(threeBitRegOperand, r); // [RULE_06]
                    stateNext.pCheck = (opGroup == RS_GROUP_OP)
                        && (funcCode >= FUNC_INVALID_LO);      // [RULE_15]
                    stateNext.addOuter = 1'b0;
                    stateNext.addAfter = '0;
                    stateNext.phase = ST_DONE;
                    if (shortForm) begin
                        // Low bit of the word displacement is ignored
                        ea = base + {10'h000, innerDisplacement[5:1],
                                     1'b0};                    // [RULE_11]
                        if (shortIndirect) begin
                            stateNext.memAddr = ea;            // [RULE_11]
                            stateNext.phase = ST_FETCH;
                        end
                    end else begin
                        case (operandAddressingField)
                            AM_REG: ea = base;                 // [RULE_01]
                            AM_REG_INC: begin
                                ea = base;                     // [RULE_02]
                                stateNext.gpr[r] = base
                                    + size_bytes(operandSize); // [RULE_02]
                            end
                            AM_DISP: ea = base + innerDisplacement; // [RULE_03]
                            default: begin
                                stateNext.phase = ST_FETCH;
                                case (indirectForm)
                                    IND_BYTE_DISP: stateNext.memAddr = base
                                        + {8'h00, innerDisplacement[7:0]}; // [RULE_05]
                                    IND_TWO_DISP: begin
                                        stateNext.memAddr = base
                                            + innerDisplacement; // [RULE_04]
                                        stateNext.addOuter = 1'b1;
                                        stateNext.addAfter =
                                            outerDisplacement;   // [RULE_04]
                                    end
                                    default: stateNext.memAddr = base
                                        + innerDisplacement;     // [RULE_12]
                                endcase
                            end
                        endcase
                    end
                    stateNext.ea = ea;
                    if (stateNext.phase == ST_DONE) begin
                        // Odd byte addresses pass; wider operands flag it
                        stateNext.alignErr = ea[0]
                            && (operandSize != SIZE_BYTE);     // [RULE_07]
                    end
                end
            end
            ST_FETCH: begin
                if (memAck) begin
                    ea = memData
                        + (stateReg.addOuter ? stateReg.addAfter
                                             : 16'h0000);      // [RULE_04]
                    stateNext.ea = ea;
                    stateNext.alignErr = ea[0]
                        && (operandSize != SIZE_BYTE);         // [RULE_07]
                    stateNext.phase = ST_DONE;
                end
            end
            ST_DONE: begin
                stateNext.done = 1'b1;
                stateNext.phase = ST_IDLE;
            end
            default: stateNext.phase = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            stateReg <= '0;
        end else begin
            stateReg <= stateNext;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reqReady     = stateReg.phase == ST_IDLE;
    assign memReq       = stateReg.phase == ST_FETCH;
    assign memAddr      = stateReg.memAddr;
    assign doneValid    = stateReg.done;
    assign effAddr      = stateReg.ea;
    assign jumpDone     = stateReg.jDone;
    assign jumpTarget   = stateReg.jTarget;
    assign jumpError    = stateReg.jErr;
    assign baseError    = stateReg.baseErr;
    assign alignError   = stateReg.alignErr;
    assign programCheck = stateReg.pCheck;
endmodule

// [dv/oag_asserts.sv]
module oag_checker
    import oag_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        srst,
    // Request side
    input wire logic        reqValid,
    input wire logic        reqReady,
    input wire logic [1:0]  operandAddressingField,
    input wire logic [3:0]  opGroup,
    input wire logic [3:0]  funcCode,
    input wire logic        jumpValid,
    input wire logic [15:0] nextInstrAddr,
    input wire logic [15:0] jumpDisp,
    input wire logic [4:0]  singleShiftCount,
    input wire logic [15:0] workAreaSize,
    // Results
    input wire logic        singleShiftOk,
    input wire logic        workAreaOk,
    input wire logic        memReq,
    input wire logic [15:0] memAddr,
    input wire logic        memAck,
    input wire logic        doneValid,
    input wire logic        jumpDone,
    input wire logic [15:0] jumpTarget,
    input wire logic        jumpError,
    input wire logic        programCheck
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    wire take = reqValid && reqReady;
    wire jumpInRange = !jumpDisp[0] &&
        (jumpDisp <= JUMP_DISP_MAX || jumpDisp >= JUMP_DISP_MIN);

    a_done_pulse: assert property (doneValid |=> !doneValid)
        else $error("done pulse longer than one cycle");
    a_take_busy: assert property (take |=> !reqReady)
        else $error("ready stayed high after a take");
    a_disp_latency: assert property (
        take && operandAddressingField == AM_DISP |-> ##2 doneValid)
        else $error("displacement result late");
    a_ind_fetch: assert property (
        take && operandAddressingField == AM_INDIRECT |=> memReq)
        else $error("indirect form did not fetch");
    a_mem_hold: assert property (
        memReq && !memAck |=> memReq && $stable(memAddr))
        else $error("fetch dropped or moved before ack");
    a_ind_done: assert property (memReq && memAck |-> ##2 doneValid)
        else $error("indirect result late");
    a_jump_sum: assert property (jumpValid && jumpInRange |=>
        jumpDone && !jumpError &&
        jumpTarget == $past(nextInstrAddr) + $past(jumpDisp))
        else $error("jump target wrong");
    a_jump_bad: assert property (jumpValid && !jumpInRange |=>
        jumpDone && jumpError)
        else $error("bad jump not flagged");
    a_shift_lim: assert property (
        singleShiftOk == (singleShiftCount <= SINGLE_SHIFT_MAX))
        else $error("single shift limit wrong");
    a_work_lim: assert property (workAreaOk ==
        (!workAreaSize[0] && workAreaSize <= WORK_AREA_MAX))
        else $error("work area limit wrong");
    a_prog_check: assert property (take && opGroup == RS_GROUP_OP &&
        funcCode >= FUNC_INVALID_LO &&
        operandAddressingField != AM_INDIRECT |-> ##2 programCheck)
        else $error("invalid function not flagged");

    c_fetch: cover property (memReq && memAck);
    c_check: cover property (doneValid && programCheck);
    c_jump_err: cover property (jumpDone && jumpError);
endmodule

bind operand_address_generator oag_checker u_oag_checker(
    .clk, .srst, .reqValid, .reqReady, .operandAddressingField, .opGroup,
    .funcCode, .jumpValid, .nextInstrAddr, .jumpDisp, .singleShiftCount,
    .workAreaSize, .singleShiftOk, .workAreaOk, .memReq, .memAddr, .memAck,
    .doneValid, .jumpDone, .jumpTarget, .jumpError, .programCheck);

// [dv/storage_model.sv]
module storage_model
    import oag_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // Read port
    input  wire logic        memReq,
    input  wire logic [15:0] memAddr,
    input  wire logic [3:0]  waitCycles,
    output logic             memAck,
    output logic      [15:0] memData
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt;
    // Word at an address is a scramble of it; outside the ack the bus
    // toggles so a stale word is never mistaken for a fresh one
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt <= '0;
            memAck <= 1'b0;
            memData <= 16'h0;
        end else if (!memReq || memAck) begin
            cnt <= '0;
            memAck <= 1'b0;
            memData <= ~memData;
        end else if (cnt == waitCycles) begin
            memAck <= 1'b1;
            memData <= memAddr ^ 16'h5a5a;
        end else begin
            cnt <= cnt + 4'h1;
            memData <= ~memData;
        end
    end
endmodule

// [dv/test_operand_address_generator.sv]
module test_operand_address_generator;
    timeunit 1ns;
    timeprecision 1ns;
    import oag_pkg::*;
    logic clk, srst, reqValid, shortForm, shortIndirect, threeBitRegOperand;
    logic jumpValid, gprWrEn, fprWrEn, memAck, reqReady, singleShiftOk;
    logic pairShiftOk, workAreaOk, memReq, doneValid, jumpDone, jumpError;
    logic baseError, alignError, programCheck;
    logic [1:0] operandAddressingField, indirectForm, operandSize;
    logic [1:0] fprWrSel, fprRdSel;
    logic [2:0] regSel, gprWrSel;
    logic [3:0] opGroup, funcCode, waitCycles;
    logic [4:0] singleShiftCount, pairShiftCount;
    logic [15:0] outerDisplacement, innerDisplacement, nextInstrAddr;
    logic [15:0] jumpDisp, workAreaSize, gprWrData, memAddr, memData;
    logic [15:0] effAddr, jumpTarget;
    logic [31:0] fprWrData, fprRdData;
    int mismatches, nChecks;

    operand_address_generator u_operand_address_generator(
        .clk, .srst, .reqValid, .reqReady, .operandAddressingField,
        .indirectForm, .shortForm, .shortIndirect, .threeBitRegOperand,
        .regSel, .operandSize, .outerDisplacement, .innerDisplacement,
        .opGroup, .funcCode, .jumpValid, .nextInstrAddr, .jumpDisp,
        .singleShiftCount, .pairShiftCount, .workAreaSize, .singleShiftOk,
        .pairShiftOk, .workAreaOk, .gprWrEn, .gprWrSel, .gprWrData, .fprWrEn,
        .fprWrSel, .fprWrData, .fprRdSel, .fprRdData, .memReq, .memAddr,
        .memAck, .memData, .doneValid, .effAddr, .jumpDone, .jumpTarget,
        .jumpError, .baseError, .alignError, .programCheck);
    storage_model u_storage_model(.clk, .srst, .memReq, .memAddr,
        .waitCycles, .memAck, .memData);

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", nChecks, mismatches);
        if (mismatches == 0 && nChecks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Storage contents as the partner presents them
    function automatic logic [15:0] mem(input logic [15:0] a);
        return a ^ 16'h5a5a;
    endfunction

    task automatic setReg(input logic [2:0] r, input logic [15:0] v);
        @(posedge clk);
        gprWrEn <= 1'b1;
        gprWrSel <= r;
        gprWrData <= v;
        @(posedge clk);
        gprWrEn <= 1'b0;
    endtask

    task automatic req(input logic [1:0] am, input logic [1:0] sz,
                       input logic [2:0] r, input logic [15:0] dIn,
                       input logic [15:0] dOut);
        @(posedge clk);
        operandAddressingField <= am;
        operandSize <= sz;
        regSel <= r;
        innerDisplacement <= dIn;
        outerDisplacement <= dOut;
        reqValid <= 1'b1;
        @(posedge clk);
        reqValid <= 1'b0;
        for (int i = 0; i < 40 && doneValid !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        chk(doneValid, 1'b1);
    endtask

    task automatic t_direct();
        logic [15:0] a;
        a = 16'h1001;
        setReg(3'h2, a);
        for (int s = 0; s < 3; s++) begin
            req(AM_REG_INC, 2'(s), 3'h2, 16'h0, 16'h0);
            chk(effAddr, a);
            a = a + (16'h1 << s);
        end
        req(AM_REG, SIZE_DOUBLE, 3'h2, 16'h0, 16'h0);
        chk(effAddr, 16'h1008);
        chk(alignError, 1'b0);
        setReg(3'h2, 16'h0003);
        req(AM_REG, SIZE_WORD, 3'h2, 16'h0, 16'h0);
        chk(alignError, 1'b1);
    endtask

    task automatic t_disp();
        setReg(3'h3, 16'hfff0);
        req(AM_DISP, SIZE_WORD, 3'h3, 16'h0020, 16'h0);
        chk(effAddr, 16'h0010);
        chk(baseError, 1'b0);
        req(AM_DISP, SIZE_WORD, 3'h0, 16'h0020, 16'h0);
        chk(baseError, 1'b1);
        threeBitRegOperand <= 1'b1;
        setReg(3'h7, 16'h0100);
        req(AM_DISP, SIZE_WORD, 3'h7, 16'hfffe, 16'h0);
        chk(effAddr, 16'h00fe);
        chk(baseError, 1'b0);
        threeBitRegOperand <= 1'b0;
    endtask

    task automatic t_ind();
        setReg(3'h1, 16'h2000);
        waitCycles <= 4'h5;
        indirectForm <= IND_BYTE_DISP;
        req(AM_INDIRECT, SIZE_BYTE, 3'h1, 16'h00ff, 16'h0);
        chk(effAddr, mem(16'h20ff));
        waitCycles <= 4'h0;
        indirectForm <= IND_TWO_DISP;
        req(AM_INDIRECT, SIZE_BYTE, 3'h1, 16'h0010, 16'h0100);
        chk(effAddr, 16'(mem(16'h2010) + 16'h0100));
        indirectForm <= IND_LONG;
        threeBitRegOperand <= 1'b1;
        setReg(3'h6, 16'h1234);
        req(AM_INDIRECT, SIZE_BYTE, 3'h6, 16'h8000, 16'h0);
        chk(effAddr, mem(16'h9234));
        threeBitRegOperand <= 1'b0;
        shortForm <= 1'b1;
        shortIndirect <= 1'b1;
        req(AM_REG, SIZE_BYTE, 3'h1, 16'h003e, 16'h0);
        chk(effAddr, mem(16'h203e));
        shortForm <= 1'b0;
        shortIndirect <= 1'b0;
    endtask

    task automatic t_jump();
        logic [15:0] d [5] = '{16'hff00, 16'h00fe, 16'h0100, 16'hfefe,
                              16'h0003};
        nextInstrAddr <= 16'h4000;
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            jumpDisp <= d[i];
            jumpValid <= 1'b1;
            @(posedge clk);
            jumpValid <= 1'b0;
            #1;
            chk(jumpDone, 1'b1);
            chk(jumpError, i > 1);
            if (i < 2) chk(jumpTarget, 16'(16'h4000 + d[i]));
        end
    endtask

    task automatic t_limits();
        for (int i = 15; i < 18; i++) begin
            @(posedge clk);
            singleShiftCount <= 5'(i);
            pairShiftCount <= 5'(i + 14);
            workAreaSize <= 16'(16'h3fee + i);
            #1;
            chk(singleShiftOk, i < 17);
            chk(pairShiftOk, 1'b1);
            chk(workAreaOk, i == 16);
        end
    endtask

    task automatic t_fpr();
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            fprWrEn <= i < 4;
            fprWrSel <= 2'(i);
            fprWrData <= 32'hc0de0000 + i;
        end
        for (int i = 0; i < 4; i++) begin
            fprRdSel <= 2'(i);
            @(posedge clk);
            #1;
            chk(fprRdData, 32'hc0de0000 + i);
        end
    endtask

    task automatic t_pcheck();
        opGroup <= RS_GROUP_OP;
        for (int f = 11; f < 16; f++) begin
            funcCode <= 4'(f);
            req(AM_REG, SIZE_BYTE, 3'h2, 16'h0, 16'h0);
            chk(programCheck, f > 11);
        end
        opGroup <= 4'h0;
    endtask

    initial begin
        {srst, reqValid, shortForm, shortIndirect, threeBitRegOperand} = 5'h10;
        {jumpValid, gprWrEn, fprWrEn, operandAddressingField} = 5'h0;
        {indirectForm, operandSize, fprWrSel, fprRdSel} = 8'h0;
        {regSel, gprWrSel, opGroup, funcCode, waitCycles} = 18'h0;
        {singleShiftCount, pairShiftCount} = 10'h0;
        {outerDisplacement, innerDisplacement, nextInstrAddr} = 48'h0;
        {jumpDisp, workAreaSize, gprWrData, fprWrData} = 80'h0;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        t_direct();
        $display("direct modes finished");
        t_disp();
        $display("displacement modes finished");
        t_ind();
        $display("indirect modes finished");
        t_jump();
        $display("jumps finished");
        t_limits();
        $display("limits finished");
        t_fpr();
        $display("float registers finished");
        t_pcheck();
        $display("function codes finished");
        end_sim();
    end

    // About 120 cycles are needed; give ample margin
    initial begin
        #(5000 * 100);
        mismatches++;
        end_sim();
    end
endmodule
